/* core/rlc_reader.sv */
// serial flash read decoder: opcode, address, mode/dummy wait, data out
// assumes spi mode 0 from the host; the latency code comes from a
// configuration register in the same clock domain; read data is the
// read latency code table itself, addressed by the low 7 address bits modulo its length
`timescale 1ns/1ns
module rlc_reader (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       sck,
  input  wire logic       cs_b,
  input  wire logic [3:0] io_in,
  input  wire logic [1:0] latency_code,
  output logic      [3:0] io_out,
  output logic      [3:0] io_oe,
  output logic      [7:0] freq_limit
);

  typedef struct packed {
    rlc_pkg::rlc_state_e st;
    logic                sck_d;
    rlc_pkg::rlc_rtype_e rt;
    logic [1:0]          code;
    logic [5:0]          edges;
    logic [31:0]         sh;
    logic [7:0]          wcnt;
    logic [6:0]          ptr;
    logic [7:0]          cur;
    logic [7:0]          obyte;
    logic [3:0]          obits;
    rlc_pkg::rlc_drive_s drv;
    logic [7:0]          flim;
  } rlc_reader_s;

  rlc_pkg::rlc_pins_s pin_raw;
  rlc_pkg::rlc_pins_s pin;
  rlc_reader_s        r;
  rlc_reader_s        next_r;

  assign pin_raw = '{sck: ~sck, cs_b: cs_b, io: io_in}; // inverted: idle high

  rlc_sync #(
    .W ($bits(rlc_pkg::rlc_pins_s))
  ) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (pin_raw),
    .q     (pin)
  );

  logic       rise;
  logic       fall;
  logic [2:0] in_lanes;
  logic [2:0] out_lanes;

  assign rise = ~pin.sck & ~r.sck_d;
  assign fall = pin.sck & r.sck_d;

  always_comb
  begin
    case (r.rt)
      rlc_pkg::RT_DIO: in_lanes = 3'h2;
      rlc_pkg::RT_QIO: in_lanes = 3'h4;
      default:         in_lanes = 3'h1;
    endcase
    case (r.rt)
      rlc_pkg::RT_READ, rlc_pkg::RT_FAST: out_lanes = 3'h1;
      rlc_pkg::RT_DOUT, rlc_pkg::RT_DIO:  out_lanes = 3'h2;
      default:                            out_lanes = 3'h4;
    endcase
  end

  always_comb
  begin
    logic [31:0] nsh;
    logic        hit;
    logic [6:0]  row;
    logic [6:0]  idx;
    logic [7:0]  mode_c;
    logic [7:0]  lat_c;
    logic [7:0]  byte_v;
    logic [5:0]  aedges;
    nsh    = r.sh;
    hit    = 1'b0;
    row    = rlc_pkg::row_base(r.code);
    idx    = '0;
    mode_c = '0;
    lat_c  = '0;
    byte_v = '0;
    aedges = '0;
    next_r = r;
    next_r.sck_d = ~pin.sck;
    next_r.flim  = rlc_pkg::RLC_TABLE[rlc_pkg::row_base(latency_code)];
    if (pin.cs_b)
    begin
      next_r.st  = rlc_pkg::ST_IDLE;
      next_r.drv = '0;
    end
    else
    begin
      case (r.st)
        rlc_pkg::ST_IDLE:
        begin
          next_r.st    = rlc_pkg::ST_CMD;
          next_r.rt    = rlc_pkg::RT_READ;
          next_r.code  = latency_code;
          next_r.edges = rlc_pkg::CMD_EDGES;
          next_r.obits = '0;
        end
        rlc_pkg::ST_CMD:
        begin
          if (rise)
          begin
            nsh          = {r.sh[30:0], pin.io[0]};
            next_r.sh    = nsh;
            next_r.edges = r.edges - 6'h01;
            if (r.edges == 6'h01)
            begin
              next_r.st = rlc_pkg::ST_IGNORE;
              for (int i = 0; i < rlc_pkg::OPC_NUM; i++)
              begin
                idx = rlc_pkg::OPC_BASE + 7'(i);
                if (rlc_pkg::RLC_TABLE[idx] == nsh[7:0])
                begin
                  // opcodes pair up: even 3-byte, odd 4-byte address
                  hit       = 1'b1;
                  next_r.rt = rlc_pkg::rlc_rtype_e'(3'(i >> 1));
                  aedges    = i[0] ? rlc_pkg::ADDR4 : rlc_pkg::ADDR3;
                end
              end
              idx    = row + rlc_pkg::ROW_MODE + 7'({next_r.rt, 1'b0});
              mode_c = rlc_pkg::RLC_TABLE[idx];
              lat_c  = rlc_pkg::RLC_TABLE[idx + 7'h01];
              // unsupported at this code: stay quiet until deselect
              if (hit && lat_c != rlc_pkg::NOT_SUPP)
              begin
                next_r.st    = rlc_pkg::ST_ADDR;
                next_r.wcnt  = mode_c + lat_c;
                case (next_r.rt)
                  rlc_pkg::RT_DIO: next_r.edges = aedges >> 1;
                  rlc_pkg::RT_QIO: next_r.edges = aedges >> 2;
                  default:         next_r.edges = aedges;
                endcase
              end
            end
          end
        end
        rlc_pkg::ST_ADDR:
        begin
          if (rise)
          begin
            case (in_lanes)
              3'h2:    nsh = {r.sh[29:0], pin.io[1:0]};
              3'h4:    nsh = {r.sh[27:0], pin.io[3:0]};
              default: nsh = {r.sh[30:0], pin.io[0]};
            endcase
            next_r.sh    = nsh;
            next_r.edges = r.edges - 6'h01;
            if (r.edges == 6'h01)
            begin
              next_r.ptr = (nsh[6:0] > rlc_pkg::PTR_LAST) ?
                           nsh[6:0] - rlc_pkg::PTR_SPAN : nsh[6:0];
              next_r.st  = (r.wcnt == 8'h00) ? rlc_pkg::ST_DATA
                                             : rlc_pkg::ST_WAIT;
            end
          end
        end
        rlc_pkg::ST_WAIT:
        begin
          // mode bits are taken but not acted on
          if (rise)
          begin
            next_r.wcnt = r.wcnt - 8'h01;
            if (r.wcnt == 8'h01)
            begin
              next_r.st = rlc_pkg::ST_DATA;
            end
          end
        end
        rlc_pkg::ST_DATA:
        begin
          if (fall)
          begin
            byte_v = r.obyte;
            if (r.obits == 4'h0)
            begin
              byte_v     = rlc_pkg::RLC_TABLE[r.ptr];
              next_r.cur = byte_v;
              next_r.ptr = (r.ptr == rlc_pkg::PTR_LAST) ? '0
                                                        : r.ptr + 7'h01;
            end
            next_r.obyte = byte_v << out_lanes;
            next_r.obits = ((r.obits == 4'h0) ? 4'h8 : r.obits)
                           - 4'(out_lanes);
            case (out_lanes)
              3'h1:
              begin
                next_r.drv.out = {2'b00, byte_v[7], 1'b0};
                next_r.drv.oe  = 4'b0010;
              end
              3'h2:
              begin
                next_r.drv.out = {2'b00, byte_v[7:6]};
                next_r.drv.oe  = 4'b0011;
              end
              default:
              begin
                next_r.drv.out = byte_v[7:4];
                next_r.drv.oe  = 4'b1111;
              end
            endcase
          end
        end
        rlc_pkg::ST_IGNORE:
        begin
          next_r.drv = '0;
        end
        default:
        begin
          next_r.st = rlc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      r       <= '0;
      r.st    <= rlc_pkg::ST_IDLE;
      r.sck_d <= 1'b0;
      r.code  <= rlc_pkg::CODE_RST;
      r.flim  <= rlc_pkg::RLC_TABLE[rlc_pkg::ROW_C11];
    end
    else
    begin
      r <= next_r;
    end
  end

  assign io_out     = r.drv.out;
  assign io_oe      = r.drv.oe;
  assign freq_limit = r.flim;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_wait_entry;
    $past(r.st) == rlc_pkg::ST_CMD && r.st == rlc_pkg::ST_ADDR;
  endsequence

  chk_oe_deselect: assert property (
    pin.cs_b |=> io_oe == 4'h0)
    else $error("pins driven while deselected");

  chk_plain_unsupp: assert property (
    r.st == rlc_pkg::ST_ADDR && r.rt == rlc_pkg::RT_READ |-> r.code == 2'h3)
    else $error("plain read accepted at a code that forbids it");

  chk_zero_wait: assert property (
    s_wait_entry ##0 (r.code == 2'h3 && r.rt < rlc_pkg::RT_DIO)
      |-> r.wcnt == 8'h00)
    else $error("single or output read waits at code 11b");

  chk_dio_wait: assert property (
    s_wait_entry ##0 (r.code == 2'h3 && r.rt == rlc_pkg::RT_DIO)
      |-> r.wcnt == 8'h04)
    else $error("dual io wait is not four cycles");

  chk_qio_wait: assert property (
    s_wait_entry ##0 (r.code == 2'h3 && r.rt == rlc_pkg::RT_QIO)
      |-> r.wcnt == 8'h03)
    else $error("quad io wait is not mode plus one");

  chk_data_start: assert property (
    r.st == rlc_pkg::ST_WAIT && r.wcnt == 8'h01 && rise && !pin.cs_b
      |=> r.st == rlc_pkg::ST_DATA)
    else $error("data did not follow the last dummy cycle");

  chk_ptr_range: assert property (
    r.ptr <= rlc_pkg::PTR_LAST)
    else $error("table pointer past the end");

  chk_header_byte: assert property (
    r.st == rlc_pkg::ST_DATA && fall && r.obits == 4'h0 && r.ptr == 7'h04
      && !pin.cs_b |=> r.cur == 8'h46)
    else $error("header row does not start with F");

  chk_freq_limit: assert property (
    $past(latency_code) == 2'h3 |-> freq_limit == 8'h32)
    else $error("code 11b limit is not 50 MHz");

endmodule

/* core/rlc_pkg.sv */
// constants, types and the read latency code table for the read decoder
// assumes a single 10 MHz clock that oversamples the serial clock
package rlc_pkg;

  localparam int unsigned TABLE_LEN = 88;

  // whole read latency code table parameter, offset 00h first
  localparam logic [0:TABLE_LEN-1][7:0] RLC_TABLE = {
    8'h90, 8'h56, 8'h06, 8'h0e,
    8'h46, 8'h43,
    8'h03, 8'h13, 8'h0b, 8'h0c, 8'h3b, 8'h3c,
    8'h6b, 8'h6c, 8'hbb, 8'hbc, 8'heb, 8'hec,
    8'h32, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h02, 8'h01,
    8'h50, 8'h00, 8'hff, 8'hff, 8'h00, 8'h08, 8'h00,
    8'h08, 8'h00, 8'h08, 8'h00, 8'h04, 8'h02, 8'h04,
    8'h5a, 8'h01, 8'hff, 8'hff, 8'h00, 8'h08, 8'h00,
    8'h08, 8'h00, 8'h08, 8'h00, 8'h05, 8'h02, 8'h04,
    8'h68, 8'h02, 8'hff, 8'hff, 8'h00, 8'h08, 8'h00,
    8'h08, 8'h00, 8'h08, 8'h00, 8'h06, 8'h02, 8'h05,
    8'h85, 8'h02, 8'hff, 8'hff, 8'h00, 8'h08, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff
  };

  localparam logic [6:0] OPC_BASE  = 7'h06;
  localparam int unsigned OPC_NUM  = 12;
  localparam logic [6:0] ROW_C11   = 7'h12;
  localparam logic [6:0] ROW_C00   = 7'h20;
  localparam logic [6:0] ROW_C01   = 7'h2e;
  localparam logic [6:0] ROW_C10   = 7'h3c;
  localparam logic [6:0] ROW_MODE  = 7'h02;
  localparam logic [6:0] PTR_LAST  = 7'h57;
  localparam logic [6:0] PTR_SPAN  = 7'h58;
  localparam logic [7:0] NOT_SUPP  = 8'hff;
  localparam logic [5:0] CMD_EDGES = 6'h08;
  localparam logic [5:0] ADDR3     = 6'h18;
  localparam logic [5:0] ADDR4     = 6'h20;
  localparam logic [1:0] CODE_RST  = 2'h3;

  typedef enum logic [2:0] {
    RT_READ, RT_FAST, RT_DOUT, RT_QOUT, RT_DIO, RT_QIO
  } rlc_rtype_e;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_WAIT, ST_DATA, ST_IGNORE
  } rlc_state_e;

  typedef struct packed {
    logic       sck;
    logic       cs_b;
    logic [3:0] io;
  } rlc_pins_s;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } rlc_drive_s;

  // row of the table that governs a latency code
  function automatic logic [6:0] row_base(input logic [1:0] code);
    case (code)
      2'h0:    row_base = ROW_C00;
      2'h1:    row_base = ROW_C01;
      2'h2:    row_base = ROW_C10;
      default: row_base = ROW_C11;
    endcase
  endfunction

endpackage

/* core/rlc_sync.sv */
// two-flop synchroniser, one stage pair per bit
// assumes inputs come from pins outside the clk domain
`timescale 1ns/1ns
module rlc_sync #(
  parameter int unsigned W = 6
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk)
      begin
        if (!rst_b)
        begin
          meta[i] <= 1'b1;
          q[i]    <= 1'b1;
        end
        else
        begin
          meta[i] <= d[i];
          q[i]    <= meta[i];
        end
      end
    end
  endgenerate

endmodule

/* verif/rlc_host.sv */
// host model: issues spi mode 0 read frames and collects the read bytes
// assumes the device drives on sck falls and holds until the next fall
`timescale 1ns/1ns
module rlc_host (
  input  wire logic       clk,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe,
  output logic            sck,
  output logic            cs_b,
  output logic      [3:0] io_in
);
  logic [7:0] rx_q[$];
  logic [3:0] oe_seen;
  logic [3:0] pat;

  initial
  begin
    sck = 1'b0;
    cs_b = 1'b1;
    io_in = 4'h5;
    pat = 4'h5;
  end

  // half of the 800 ns serial clock, far below every code's limit
  task automatic half();
    repeat (4) @(posedge clk);
  endtask

  // one rising edge; lanes outside m carry a toggling pattern
  task automatic edge_out(input logic [3:0] v, input logic [3:0] m);
    pat = ~pat;
    io_in <= (v & m) | (pat & ~m);
    half();
    sck <= 1'b1;
    half();
    sck <= 1'b0;
  endtask

  task automatic xfer(input logic [7:0] op, input logic [31:0] addr,
                      input int alen, input int al, input int waits,
                      input int dl, input int nbytes);
    logic [31:0] a;
    logic [7:0]  b;
    int          i;
    rx_q.delete();
    oe_seen = 4'h0;
    b = 8'h00;
    a = addr << (32 - 8 * alen);
    cs_b <= 1'b0;
    half();
    for (i = 7; i >= 0; i--)
      edge_out({3'h0, op[i]}, 4'h1);
    for (i = 0; i < 8 * alen / al; i++)
    begin
      edge_out(a[31:28] >> (4 - al), 4'((1 << al) - 1));
      a = a << al;
    end
    for (i = 0; i < waits; i++)
      edge_out(4'h0, 4'h0);
    for (i = 0; i < nbytes * 8 / dl; i++)
    begin
      half();
      sck <= 1'b1;
      io_in <= ~io_in;
      half();
      oe_seen = oe_seen | io_oe;
      if (dl == 1)
        b = {b[6:0], io_out[1]};
      else if (dl == 2)
        b = {b[5:0], io_out[1:0]};
      else
        b = {b[3:0], io_out};
      if ((i + 1) % (8 / dl) == 0)
        rx_q.push_back(b);
      sck <= 1'b0;
    end
    half();
    cs_b <= 1'b1;
    repeat (2) half();
  endtask
endmodule

/* verif/tb_rlc_reader.sv */
// self-checking bench for the read decoder against a host model
// assumes one 10 MHz clock; the host model makes the serial clock
`timescale 1ns/1ns
module tb_rlc_reader;
  logic       clk;
  logic       rst_b;
  logic [1:0] latency_code;
  logic       sck;
  logic       cs_b;
  logic [3:0] io_in;
  logic [3:0] io_out;
  logic [3:0] io_oe;
  logic [7:0] freq_limit;
  int         bad_count;
  int         num_checks;
  int         seed;
  int         i;
  int         c;
  // head of the table, offsets 00h to 23h
  logic [7:0] tab [36] = '{8'h90, 8'h56, 8'h06, 8'h0e, 8'h46, 8'h43,
    8'h03, 8'h13, 8'h0b, 8'h0c, 8'h3b, 8'h3c, 8'h6b, 8'h6c, 8'hbb, 8'hbc,
    8'heb, 8'hec, 8'h32, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h04, 8'h02, 8'h01, 8'h50, 8'h00, 8'hff, 8'hff};
  // mode plus dummy cycles by code and type, -1 when refused
  int         wt [4][6] = '{'{-1, 8, 8, 8, 4, 6}, '{-1, 8, 8, 8, 5, 6},
                            '{-1, 8, 8, 8, 6, 7}, '{0, 0, 0, 0, 4, 3}};
  int         al [6] = '{1, 1, 1, 1, 2, 4};
  int         dl [6] = '{1, 1, 2, 4, 2, 4};
  logic [7:0] fx [4] = '{8'h50, 8'h5a, 8'h68, 8'h32};

  rlc_reader DUT (
    .clk          (clk),
    .rst_b        (rst_b),
    .sck          (sck),
    .cs_b         (cs_b),
    .io_in        (io_in),
    .latency_code (latency_code),
    .io_out       (io_out),
    .io_oe        (io_oe),
    .freq_limit   (freq_limit)
  );

  rlc_host host (
    .clk    (clk),
    .io_out (io_out),
    .io_oe  (io_oe),
    .sck    (sck),
    .cs_b   (cs_b),
    .io_in  (io_in)
  );

  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one read frame of opcode index x under code k, checked byte by byte
  task automatic run(input int k, input int x, input logic [31:0] adr,
                     input int n);
    int         t;
    int         w;
    logic [3:0] m;
    t = x / 2;
    w = wt[k][t];
    latency_code <= 2'(k);
    @(posedge clk);
    host.xfer(tab[6 + x], adr, 3 + x % 2, al[t], (w < 0) ? 0 : w, dl[t], n);
    m = (dl[t] == 1) ? 4'h2 : 4'((1 << dl[t]) - 1);
    if (w < 0)
      m = 4'h0;
    chk("oe", {4'h0, m}, {4'h0, host.oe_seen});
    for (int j = 0; j < n && w >= 0; j++)
      chk("data", tab[(adr[6:0] + j) % 88], host.rx_q[j]);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    bad_count++;
    $display("Error watchdog expected done seen hang");
    close_out();
  end

  initial
  begin
    logic [31:0] r;
    logic [31:0] a;
    rst_b = 1'b0;
    latency_code = 2'h3;
    bad_count = 0;
    num_checks = 0;
    seed = 65;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    for (i = 0; i < 4; i++)
    begin
      latency_code <= 2'(i);
      repeat (3) @(posedge clk);
      chk("freq", fx[i], freq_limit);
    end
    $display("test freq limits done");
    run(3, 2, 32'h0, 6);
    // next parameter sits at the length byte's offset plus length plus one
    run(3, 1, 32'(tab[1]) + 32'h2, 1);
    $display("test table header done");
    for (c = 3; c >= 0; c--)
      for (i = 0; i < 12; i++)
      begin
        r = $random(seed);
        a = {r[31:8], 8'(r[7:0] % 8'd34)};
        if (c == 3)
          run(c, i, a, 2);
        else
          run(c, i, a, 2);
      end
    $display("test reads by code done");
    host.xfer(8'h9f, 32'h0, 3, 1, 0, 1, 1);
    chk("oe", 8'h00, {4'h0, host.oe_seen});
    $display("test unknown opcode done");
    close_out();
  end
endmodule
